// ---- core/pm_smi_status_and_idle_timer.sv ----
/*
  Second level SMI status mirrors with clear-on-read counterparts and the
  reloadable general timer one, reached over a plain register port.
  Assumes all event inputs are one-cycle pulses from logic on clk, and the
  spare and lid switch pins arrive asynchronously from outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pm_status_defs.svh"
module pm_smi_status_and_idle_timer #(
  parameter int unsigned MSEC_CYCLES = (`MSEC_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int unsigned SEC_TICKS   = `TICKS_PER_SEC
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire pm_status_pkg::reg_req_t  regReq,
  output logic [`DATA_W-1:0]            readData,
  input  wire pm_status_pkg::pm_events_t events,
  input  wire logic [2:0]               sparePins,
  input  wire logic [2:0]               spareSelected,
  input  wire logic                     lidSwitchPin,
  input  wire logic                     userDeviceThreeAccess,
  output logic                          smiRequest,
  output logic                          topEventStatus,
  output logic                          topTimerStatus,
  output logic                          timerExpiredStatus
);
  if (MSEC_CYCLES < 2 || SEC_TICKS < 2) begin : gBadTimebase
    $error("Timebase counts must be at least two.");
  end

  logic [7:0] trapEnableA, trapEnableB, codecEnable, pinDir, pinSmi, widthSel;
  logic [7:0] reloadValue, control, upperCount;
  logic [5:0] trapStatus;
  logic [7:0] miscStatus;
  logic [2:0] spareMeta, spareSync, spareLast;
  logic       lidMeta, lidSync, lidLast;
  logic [15:0] timerCount;
  logic [31:0] msecCount;
  logic [31:0] secCount;
  logic        msecTick, tick;
  logic        wasEnabled;
  pm_status_pkg::timer_state_t timerState;

  wire logic wr = regReq.write;
  wire logic rd = regReq.read;
  wire logic [`ADDR_W-1:0] addr = regReq.addr;
  wire logic timerEnable = trapEnableB[`BIT_TIMER_ENABLE];
  wire logic wide = widthSel[`BIT_WIDE_SELECT];

  // Registers written by software.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trapEnableA <= `RESET_BYTE;
      trapEnableB <= `RESET_BYTE;
      codecEnable <= `RESET_BYTE;
      pinDir      <= `RESET_BYTE;
      pinSmi      <= `RESET_BYTE;
      widthSel    <= `RESET_BYTE;
      reloadValue <= `RESET_BYTE;
      control     <= `RESET_BYTE;
      upperCount  <= `RESET_BYTE;
    end else if (wr) begin
      unique case (addr)
        `OFF_TRAP_ENABLE_A: trapEnableA <= regReq.wdata;
        `OFF_TRAP_ENABLE_B: trapEnableB <= regReq.wdata;
        `OFF_CODEC_ENABLE:  codecEnable <= regReq.wdata;
        `OFF_PIN_DIR:       pinDir      <= regReq.wdata;
        `OFF_PIN_SMI:       pinSmi      <= regReq.wdata;
        `OFF_WIDTH_SEL:     widthSel    <= regReq.wdata;
        `OFF_RELOAD:        reloadValue <= regReq.wdata;
        `OFF_CONTROL:       control     <= regReq.wdata;
        `OFF_UPPER_COUNT:   upperCount  <= regReq.wdata;
        default: ;
      endcase
    end
  end

  // Pin synchronisers; only the second stage and its one-cycle delayed third stage feed logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spareMeta <= 3'h0;
      spareSync <= 3'h0;
      spareLast <= 3'h0;
      lidMeta   <= 1'b0;
      lidSync   <= 1'b0;
      lidLast   <= 1'b0;
    end else begin
      spareMeta <= sparePins;
      spareSync <= spareMeta;
      spareLast <= spareSync;
      lidMeta   <= lidSwitchPin;
      lidSync   <= lidMeta;
      lidLast   <= lidSync;
    end
  end

  wire logic lidConfigured = !pinDir[`BIT_LID] && pinSmi[`BIT_LID];
  wire logic lidEvent = lidConfigured && (lidSync != lidLast);

  logic [2:0] spareEvent;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gSpare
      assign spareEvent[g] = spareSelected[g] && !pinDir[g] && pinSmi[g]
                             && (spareSync[g] != spareLast[g]);
    end
  endgenerate

  logic [5:0] trapSet;
  assign trapSet = {
    events.secDiskTrap && trapEnableB[`BIT_SEC_DISK_TRAP],
    events.secDiskIdle && trapEnableB[`BIT_SEC_DISK_IDLE],
    events.kbdTrap     && trapEnableA[`BIT_KBD_TRAP],
    events.serParTrap  && trapEnableA[`BIT_SER_PAR_TRAP],
    events.floppyTrap  && trapEnableA[`BIT_FLOPPY_TRAP],
    events.priDiskTrap && trapEnableA[`BIT_PRI_DISK_TRAP]};

  logic [7:0] miscSet;
  assign miscSet = {
    spareEvent[2], spareEvent[1], spareEvent[0],
    1'b0,
    lidEvent,
    events.codecEdge && codecEnable[`BIT_CODEC_ENABLE],
    events.rtcAlarm && events.suspend3v,
    events.acpiToggle && trapEnableB[`BIT_ACPI_ENABLE]};

  wire logic trapClear = rd && addr == `OFF_TRAP_CLEAR;
  wire logic miscClear = rd && addr == `OFF_MISC_CLEAR;

  // One flop per status bit serves both views; a set wins over a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trapStatus <= 6'h00;
    end else begin
      trapStatus <= (trapClear ? 6'h00 : trapStatus) | trapSet;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miscStatus <= 8'h00;
    end else begin
      miscStatus <= (miscClear ? 8'h00 : miscStatus) | miscSet;
    end
  end

  // Timebase dividers; select 0 is one second, 1 is one millisecond.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msecCount <= 32'h0;
      msecTick  <= 1'b0;
    end else if (msecCount == MSEC_CYCLES - 1) begin
      msecCount <= 32'h0;
      msecTick  <= 1'b1;
    end else begin
      msecCount <= msecCount + 32'h1;
      msecTick  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secCount <= 32'h0;
    end else if (msecTick) begin
      secCount <= (secCount == SEC_TICKS - 1) ? 32'h0 : secCount + 32'h1;
    end
  end

  assign tick = control[`BIT_TIMEBASE] ? msecTick
              : (msecTick && secCount == SEC_TICKS - 1);

  // A count write loads the byte being written, not the stale register.
  wire logic [7:0]  next_reloadValue = (wr && addr == `OFF_RELOAD) ? regReq.wdata
                                                                   : reloadValue;
  wire logic [7:0]  next_upperCount  = (wr && addr == `OFF_UPPER_COUNT) ? regReq.wdata
                                                                        : upperCount;
  wire logic [15:0] loadValue = wide ? {next_upperCount, next_reloadValue}
                                     : {8'h00, next_reloadValue};
  wire logic retrigger = |(events.activity & control[`ACTIVITY_MSB:0])
                       || (userDeviceThreeAccess && control[`BIT_USER_DEV_RETRIG]);
  wire logic countWrite = wr && (addr == `OFF_RELOAD
                                 || (wide && addr == `OFF_UPPER_COUNT));

  // Timer one: loads on enable, reloads on activity, counts down per tick.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerState <= pm_status_pkg::TMR_IDLE;
      timerCount <= 16'h0;
      wasEnabled <= 1'b0;
    end else begin
      wasEnabled <= timerEnable;
      unique case (timerState)
        pm_status_pkg::TMR_IDLE: begin
          if (timerEnable && !wasEnabled) begin
            timerCount <= loadValue;
            timerState <= pm_status_pkg::TMR_RUN;
          end
        end
        pm_status_pkg::TMR_RUN: begin
          if (!timerEnable) begin
            timerState <= pm_status_pkg::TMR_IDLE;
          end else if (retrigger || countWrite) begin
            timerCount <= loadValue;
          end else if (timerCount == 16'h0) begin
            timerState <= pm_status_pkg::TMR_EXPIRED;
          end else if (tick) begin
            timerCount <= timerCount - 16'h1;
          end
        end
        pm_status_pkg::TMR_EXPIRED: begin
          if (!timerEnable) begin
            timerState <= pm_status_pkg::TMR_IDLE;
          end else if (countWrite) begin
            timerCount <= loadValue;
            timerState <= pm_status_pkg::TMR_RUN;
          end
        end
      endcase
    end
  end

  wire logic expiring = timerState == pm_status_pkg::TMR_RUN && timerEnable
                        && !retrigger && !countWrite && timerCount == 16'h0;
  wire logic timerStatusClear = wr && addr == `OFF_TIMER_STATUS
                                && regReq.wdata[`BIT_TOP_EVENT];
  wire logic topClear = wr && addr == `OFF_TIMER_STATUS
                        && regReq.wdata[`BIT_TOP_TIMER];

  // Top level and timer status flags, set wins; timer flags are write-one-to-clear, top event clears on a clearing read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      topEventStatus     <= 1'b0;
      topTimerStatus     <= 1'b0;
      timerExpiredStatus <= 1'b0;
      smiRequest         <= 1'b0;
    end else begin
      topEventStatus <= (|trapSet) || (|miscSet)
                        || (topEventStatus && !(trapClear || miscClear));
      topTimerStatus     <= expiring || (topTimerStatus && !topClear);
      timerExpiredStatus <= expiring || (timerExpiredStatus && !timerStatusClear);
      smiRequest         <= expiring || (|trapSet) || (|miscSet);
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= `RESET_BYTE;
    end else if (rd) begin
      unique case (addr)
        `OFF_TRAP_MIRROR, `OFF_TRAP_CLEAR: readData <= {2'b00, trapStatus};
        `OFF_MISC_MIRROR, `OFF_MISC_CLEAR:
          readData <= {miscStatus[7:5], lidConfigured && lidSync,
                       miscStatus[3:0]};
        `OFF_RELOAD:        readData <= reloadValue;
        `OFF_CONTROL:       readData <= control;
        `OFF_TRAP_ENABLE_A: readData <= trapEnableA;
        `OFF_TRAP_ENABLE_B: readData <= trapEnableB;
        `OFF_CODEC_ENABLE:  readData <= codecEnable;
        `OFF_PIN_DIR:       readData <= pinDir;
        `OFF_PIN_SMI:       readData <= pinSmi;
        `OFF_WIDTH_SEL:     readData <= widthSel;
        `OFF_UPPER_COUNT:   readData <= upperCount;
        `OFF_TIMER_STATUS:
          readData <= {6'h00, topTimerStatus, timerExpiredStatus};
        default:            readData <= `RESET_BYTE;
      endcase
    end else begin
      readData <= `RESET_BYTE;
    end
  end
endmodule
`default_nettype wire

// ---- common/pm_status_defs.svh ----
/*
  Offsets, field positions, reset values and timing figures for the power
  management status mirrors and general timer one.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef PM_STATUS_DEFS_SVH
`define PM_STATUS_DEFS_SVH

`define ADDR_W              8
`define DATA_W              8
`define OFF_TRAP_MIRROR     8'h86
`define OFF_MISC_MIRROR     8'h87
`define OFF_RELOAD          8'h88
`define OFF_CONTROL         8'h89
`define OFF_TRAP_CLEAR      8'hf6
`define OFF_MISC_CLEAR      8'hf7
`define OFF_TRAP_ENABLE_A   8'h82
`define OFF_TRAP_ENABLE_B   8'h83
`define OFF_CODEC_ENABLE    8'h80
`define OFF_PIN_DIR         8'h90
`define OFF_PIN_SMI         8'h92
`define OFF_WIDTH_SEL       8'h8b
`define OFF_UPPER_COUNT     8'hc0
`define OFF_TIMER_STATUS    8'hc1
`define RESET_BYTE          8'h00
`define BIT_TIMER_ENABLE    0
`define BIT_ACPI_ENABLE     5
`define BIT_SEC_DISK_TRAP   6
`define BIT_SEC_DISK_IDLE   7
`define BIT_CODEC_ENABLE    5
`define BIT_LID             6
`define BIT_WIDE_SELECT     4
`define BIT_TIMEBASE        7
`define BIT_KBD_TRAP        3
`define BIT_SER_PAR_TRAP    2
`define BIT_FLOPPY_TRAP     1
`define BIT_PRI_DISK_TRAP   0
`define BIT_USER_DEV_RETRIG 6
`define ACTIVITY_MSB        6
`define BIT_TOP_EVENT       0
`define BIT_TOP_TIMER       1
`define MSEC_NS             1000000
`define CLK_NS              40
`define TICKS_PER_SEC       1000

`endif

// ---- common/pm_status_pkg.sv ----
/*
  Types shared by the power management status block.
  Assumes pm_status_defs.svh is on the include path.
*/
`include "pm_status_defs.svh"
package pm_status_pkg;
  typedef struct packed {
    logic                 write;
    logic                 read;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   wdata;
  } reg_req_t;

  typedef struct packed {
    logic       secDiskTrap;
    logic       secDiskIdle;
    logic       kbdTrap;
    logic       serParTrap;
    logic       floppyTrap;
    logic       priDiskTrap;
    logic       codecEdge;
    logic       rtcAlarm;
    logic       acpiToggle;
    logic       suspend3v;
    logic [6:0] activity;
  } pm_events_t;

  typedef enum logic [2:0] {
    TMR_IDLE    = 3'b001,
    TMR_RUN     = 3'b010,
    TMR_EXPIRED = 3'b100
  } timer_state_t;
endpackage

// ---- verif/pm_smi_status_sva.sv ----
/*
  Checker for the status mirrors and general timer one.
  Assumes it is bound to the block top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pm_status_defs.svh"
module pm_smi_status_sva #(
  parameter int unsigned MSEC_CYCLES = 4,
  parameter int unsigned SEC_TICKS   = 3
) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire pm_status_pkg::reg_req_t   regReq,
  input wire logic [`DATA_W-1:0]        readData,
  input wire pm_status_pkg::pm_events_t events,
  input wire logic [2:0]                sparePins,
  input wire logic [2:0]                spareSelected,
  input wire logic                      lidSwitchPin,
  input wire logic                      userDeviceThreeAccess,
  input wire logic                      smiRequest,
  input wire logic                      topEventStatus,
  input wire logic                      topTimerStatus,
  input wire logic                      timerExpiredStatus
);
  logic [7:0] enA;
  logic [7:0] enB;
  logic       clrRead;
  logic       tmrClr;
  assign clrRead = regReq.read && (regReq.addr == `OFF_TRAP_CLEAR ||
                   regReq.addr == `OFF_MISC_CLEAR);
  assign tmrClr = regReq.write && regReq.addr == `OFF_TIMER_STATUS && regReq.wdata[0];
  // Shadow copies of the trap enables.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enA <= 8'h00;
      enB <= 8'h00;
    end else if (regReq.write) begin
      if (regReq.addr == `OFF_TRAP_ENABLE_A) enA <= regReq.wdata;
      if (regReq.addr == `OFF_TRAP_ENABLE_B) enB <= regReq.wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_clear_quiet;
    clrRead && events[16:8] == 9'h000;
  endsequence
  sequence s_trap_read;
    regReq.read && regReq.addr == `OFF_TRAP_MIRROR;
  endsequence
  a_read_idle_zero: assert property (!regReq.read |=> readData == 8'h00)
    else $error("read data not zero outside a read answer");
  a_trap_bit_six: assert property (s_trap_read |=> readData[6] == 1'b0)
    else $error("reserved trap bit reads one");
  a_top_stays_set: assert property (topEventStatus && !clrRead |=> topEventStatus)
    else $error("top event status dropped without a clearing read");
  a_sec_trap_smi: assert property (events.secDiskTrap && enB[6] |=> smiRequest && topEventStatus)
    else $error("secondary disk trap gave no request");
  a_idle_trap_smi: assert property (events.secDiskIdle && enB[7] |=> smiRequest)
    else $error("secondary disk idle gave no request");
  a_kbd_trap_smi: assert property (events.kbdTrap && enA[3] |=> smiRequest)
    else $error("keyboard trap gave no request");
  a_acpi_toggle_smi: assert property (events.acpiToggle && enB[5] |=> smiRequest)
    else $error("acpi toggle gave no request");
  a_clear_read_drops: assert property (s_clear_quiet |=> !topEventStatus)
    else $error("clearing read left top event status set");
  a_expiry_stays_set: assert property (timerExpiredStatus && !tmrClr |=> timerExpiredStatus)
    else $error("timer status dropped without a clear");
  a_expiry_raises_smi: assert property ($rose(timerExpiredStatus) |-> smiRequest && topTimerStatus)
    else $error("timer expiry without request or top status");
endmodule
bind pm_smi_status_and_idle_timer pm_smi_status_sva #(
  .MSEC_CYCLES(MSEC_CYCLES),
  .SEC_TICKS  (SEC_TICKS)
) pm_smi_status_sva_inst (.clk(clk), .rst_n(rst_n), .regReq(regReq), .readData(readData),
  .events(events), .sparePins(sparePins), .spareSelected(spareSelected),
  .lidSwitchPin(lidSwitchPin), .userDeviceThreeAccess(userDeviceThreeAccess),
  .smiRequest(smiRequest), .topEventStatus(topEventStatus), .topTimerStatus(topTimerStatus),
  .timerExpiredStatus(timerExpiredStatus));
`default_nettype wire

// ---- verif/test_pm_smi_status_and_idle_timer.sv ----
/*
  Self-checking bench for the status mirrors and general timer one.
  Assumes short timer parameters and the shared package on the path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pm_status_defs.svh"
module test_pm_smi_status_and_idle_timer;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  pm_status_pkg::reg_req_t   regReq = '0;
  pm_status_pkg::pm_events_t events = '0;
  logic [2:0]                sparePins = 3'h0;
  logic [2:0]                spareSelected = 3'h0;
  logic                      lidSwitchPin = 1'b0;
  logic                      userDeviceThreeAccess = 1'b0;
  logic [7:0]                readData;
  logic                      smiRequest;
  logic                      topEventStatus;
  logic                      topTimerStatus;
  logic                      timerExpiredStatus;
  int                        errors = 0;
  int                        comparisons = 0;
  always #20 clk = ~clk;
  pm_smi_status_and_idle_timer #(.MSEC_CYCLES(4), .SEC_TICKS(3)) pm_smi_status_and_idle_timer_inst (
    .clk, .rst_n, .regReq, .readData, .events, .sparePins, .spareSelected, .lidSwitchPin,
    .userDeviceThreeAccess, .smiRequest, .topEventStatus, .topTimerStatus, .timerExpiredStatus);
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk) regReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) regReq <= '0;
    @(negedge clk) check(what, exp, readData);
  endtask
  task automatic pulse(input int b, input logic sus, input logic smi);
    pm_status_pkg::pm_events_t e;
    e = '0;
    e[b] = 1'b1;
    e.suspend3v = sus;
    @(posedge clk) events <= e;
    @(posedge clk) events <= '0;
    @(negedge clk) check("smi request", {7'h0, smi}, {7'h0, smiRequest});
  endtask
  task automatic expire(input int lo, input int hi, input string what);
    int n;
    repeat (lo) @(negedge clk);
    check("timer early", 8'h00, {7'h0, timerExpiredStatus});
    n = 0;
    while (timerExpiredStatus !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    check(what, 8'h01, {7'h0, timerExpiredStatus});
    check("top timer status", 8'h01, {7'h0, topTimerStatus});
    if (timerExpiredStatus !== 1'b1) tally_and_finish();
    wr(`OFF_TIMER_STATUS, 8'h03);
    @(negedge clk) check("timer cleared", 8'h00, {7'h0, timerExpiredStatus | topTimerStatus});
  endtask
  task automatic t_registers;
    rd(`OFF_MISC_MIRROR, `RESET_BYTE, "misc reset");
    rd(`OFF_RELOAD, `RESET_BYTE, "reload reset");
    rd(`OFF_CONTROL, `RESET_BYTE, "control reset");
    wr(`OFF_RELOAD, 8'ha5);
    rd(`OFF_RELOAD, 8'ha5, "reload value");
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00, "unmapped read");
  endtask
  task automatic t_traps;
    logic [7:0] acc;
    acc = 8'h00;
    wr(`OFF_TRAP_ENABLE_A, 8'h0f);
    wr(`OFF_TRAP_ENABLE_B, 8'hc0);
    for (int i = 0; i < 6; i++) begin
      pulse(16 - i, 1'b0, 1'b1);
      acc = acc | (8'h20 >> i);
      rd(`OFF_TRAP_MIRROR, acc, "trap mirror");
    end
    check("top event", 8'h01, {7'h0, topEventStatus});
    rd(`OFF_TRAP_CLEAR, 8'h3f, "trap clear read");
    rd(`OFF_TRAP_MIRROR, 8'h00, "trap after clear");
    wr(`OFF_TRAP_ENABLE_A, 8'h00);
    pulse(14, 1'b0, 1'b0);
    rd(`OFF_TRAP_MIRROR, 8'h00, "disabled trap");
  endtask
  task automatic t_misc;
    wr(`OFF_CODEC_ENABLE, 8'h20);
    wr(`OFF_TRAP_ENABLE_B, 8'h20);
    pulse(9, 1'b0, 1'b0);
    pulse(10, 1'b0, 1'b1);
    pulse(9, 1'b1, 1'b1);
    pulse(8, 1'b0, 1'b1);
    rd(`OFF_MISC_MIRROR, 8'h07, "misc mirror");
    rd(`OFF_MISC_MIRROR, 8'h07, "misc reread");
    rd(`OFF_MISC_CLEAR, 8'h07, "misc clear read");
    rd(`OFF_MISC_MIRROR, 8'h00, "misc after clear");
  endtask
  task automatic t_pins;
    wr(`OFF_PIN_DIR, 8'h00);
    wr(`OFF_PIN_SMI, 8'h47);
    @(posedge clk) spareSelected <= 3'h7;
    sparePins <= 3'h7;
    lidSwitchPin <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`OFF_MISC_MIRROR, 8'hf8, "pin events");
    rd(`OFF_MISC_CLEAR, 8'hf8, "pin clear read");
    rd(`OFF_MISC_MIRROR, 8'h10, "lid level");
    @(posedge clk) spareSelected <= 3'h3;
    sparePins <= 3'h0;
    lidSwitchPin <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`OFF_MISC_CLEAR, 8'h68, "unselected pin");
  endtask
  task automatic t_timer;
    wr(`OFF_WIDTH_SEL, 8'h00);
    wr(`OFF_RELOAD, 8'h03);
    wr(`OFF_CONTROL, 8'h80);
    wr(`OFF_TRAP_ENABLE_B, 8'h01);
    expire(6, 30, "msec expiry");
    wr(`OFF_CONTROL, 8'h00);
    wr(`OFF_RELOAD, 8'h02);
    expire(10, 60, "sec expiry");
    wr(`OFF_TRAP_ENABLE_B, 8'h00);
    wr(`OFF_RELOAD, 8'h03);
    wr(`OFF_CONTROL, 8'hc1);
    wr(`OFF_TRAP_ENABLE_B, 8'h01);
    repeat (6) begin
      @(posedge clk) events.activity <= 7'h01;
      @(posedge clk) events.activity <= 7'h00;
      repeat (5) @(posedge clk);
      @(posedge clk) userDeviceThreeAccess <= 1'b1;
      @(posedge clk) userDeviceThreeAccess <= 1'b0;
      repeat (5) @(posedge clk);
    end
    @(negedge clk) check("retriggered", 8'h00, {7'h0, timerExpiredStatus});
    expire(2, 30, "retrigger expiry");
    wr(`OFF_TRAP_ENABLE_B, 8'h00);
    wr(`OFF_WIDTH_SEL, 8'h10);
    wr(`OFF_UPPER_COUNT, 8'h01);
    wr(`OFF_RELOAD, 8'h00);
    wr(`OFF_CONTROL, 8'h80);
    wr(`OFF_TRAP_ENABLE_B, 8'h01);
    expire(900, 300, "wide expiry");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_registers();
    t_traps();
    t_misc();
    t_pins();
    t_timer();
    tally_and_finish();
  end
endmodule
`default_nettype wire
